//--- ctpg_regs.vh
`ifndef CTPG_REGS_VH
`define CTPG_REGS_VH
// Pattern selection codes
`define CTPG_SEL_NONE 3'h0
`define CTPG_SEL_FIRST 3'h1
`define CTPG_SEL_MOV8 3'h2
`define CTPG_SEL_MOV12 3'h3
`define CTPG_SEL_FEAT8 3'h4
`define CTPG_SEL_FEAT12 3'h5
`define CTPG_SEL_COLOR 3'h6
// Widths, reset values, masks, buffer counts and flag levels
`define CTPG_SEL_W 3
`define CTPG_CNT_RST 12'h000
`define CTPG_POS_RST 12'h000
`define CTPG_PIX_RST 12'h000
`define CTPG_MASK8 12'h00FF
`define CTPG_MASK10 12'h03FF
`define CTPG_ONE 12'h001
`define CTPG_BUF_EMPTY 2'h0
`define CTPG_BUF_ONE 2'h1
`define CTPG_BUF_FULL 2'h2
`define CTPG_FLAG_SET 1'h1
`define CTPG_FLAG_CLR 1'h0
`endif

//--- ctpg_top.v
`timescale 1ns/1ps
`include "ctpg_regs.vh"
// Operation
// - Selector: off or six internal patterns
// - Analog settings ignored while pattern active
// - Patterns 1,2,3,6 bypass digital processing
// - Patterns 4,5 pass through digital processing
// - Pattern 1: column plus row mod 256
// - Frame counter increments per acquisition start
// - Pattern 2: column+row+counter mod 256
// - Pattern 3: column+row+counter mod 4096
// - Moving patterns shift one pixel per frame
// - Pattern 4: pattern 2 via processing
// - Pattern 5: pattern 3 via processing
// - Pattern 6: moving colour gradient, colour only
// - Ten-bit variant: patterns 3,5 are 10-bit
module ctpg_top #(
    parameter PIX_W = 12,
    parameter IS_COLOR = 1,
    parameter TEN_BIT = 0
)(
    input wire CLK_SYS_I,
    input wire RST_N_I,
    input wire [2:0] PATTERN_CHOICE_I,
    input wire FRAME_START_I,
    input wire [PIX_W-1:0] COL_I,
    input wire [PIX_W-1:0] ROW_I,
    input wire SENSOR_VALID_I,
    input wire [PIX_W-1:0] SENSOR_RAW_I,
    input wire [PIX_W-1:0] SENSOR_ANALOG_I,
    input wire [PIX_W-1:0] DIGITAL_PROC_I,
    output wire SENSOR_READY_O,
    output reg [PIX_W-1:0] PROC_IN_O,
    output reg USE_ANALOG_O,
    output reg USE_DIGITAL_O,
    output wire PIX_VALID_O,
    output wire [PIX_W-1:0] PIX_DATA_O,
    input wire PIX_READY_I
);
    reg [2:0] sel_reg;
    reg [PIX_W-1:0] frame_cnt_reg;
    reg [PIX_W-1:0] gen_pix;
    reg [PIX_W-1:0] out_pix;
    reg [PIX_W-1:0] buf0_reg;
    reg [PIX_W-1:0] buf1_reg;
    reg [1:0] cnt_reg;
    wire pat_on;
    wire bypass;
    wire push;
    wire pop;
    wire [PIX_W-1:0] mask12;
    wire take;
    reg stage_valid_reg;
    reg stage_byp_reg;

    // Width mask for the wide moving patterns
    assign mask12 = TEN_BIT ? `CTPG_MASK10 : {PIX_W{1'b1}};

    // Diagonal sum with optional offset; shared by all gradients
    function [PIX_W-1:0] diag;
        input [PIX_W-1:0] c;
        input [PIX_W-1:0] r;
        input [PIX_W-1:0] off;
        input [PIX_W-1:0] m;
        begin
            diag = (c + r + off) & m;
        end
    endfunction

    // Selection sampled only at frame start so a frame is never mixed
    always @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            sel_reg <= `CTPG_SEL_NONE;
        else if (FRAME_START_I)
        begin
            if (PATTERN_CHOICE_I == `CTPG_SEL_COLOR && IS_COLOR == 0)
                sel_reg <= `CTPG_SEL_NONE;
            else if (PATTERN_CHOICE_I > `CTPG_SEL_COLOR)
                sel_reg <= `CTPG_SEL_NONE;
            else
                sel_reg <= PATTERN_CHOICE_I;
        end
    end

    // Frame counter; full-width wrap covers every pattern modulus
    always @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            frame_cnt_reg <= `CTPG_CNT_RST;
        else if (FRAME_START_I)
            frame_cnt_reg <= frame_cnt_reg + `CTPG_ONE;
    end

    // Mode decode; the feature patterns keep the digital chain in the path
    assign pat_on = (sel_reg != `CTPG_SEL_NONE);
    assign bypass = pat_on && (sel_reg != `CTPG_SEL_FEAT8) && (sel_reg != `CTPG_SEL_FEAT12);

    // Pattern generator for the pixel presented this cycle
    // Unused codes give zero, but those never reach the output path
    always @*
    begin
        gen_pix = `CTPG_PIX_RST;
        case (sel_reg)
            `CTPG_SEL_FIRST:
                gen_pix = diag(COL_I, ROW_I, `CTPG_PIX_RST, `CTPG_MASK8);
            `CTPG_SEL_MOV8, `CTPG_SEL_FEAT8:
                gen_pix = diag(COL_I, ROW_I, frame_cnt_reg, `CTPG_MASK8);
            `CTPG_SEL_MOV12, `CTPG_SEL_FEAT12:
                gen_pix = diag(COL_I, ROW_I, frame_cnt_reg, mask12);
            `CTPG_SEL_COLOR:
                gen_pix = diag(COL_I, ROW_I, frame_cnt_reg, `CTPG_MASK8);
            default:
                gen_pix = `CTPG_PIX_RST;
        endcase
    end

    // Path steering: analog chain off with any pattern, digital off for bypass ones
    always @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            USE_ANALOG_O <= `CTPG_FLAG_SET;
            USE_DIGITAL_O <= `CTPG_FLAG_SET;
        end
        else
        begin
            USE_ANALOG_O <= !pat_on;
            USE_DIGITAL_O <= !bypass;
        end
    end

    // Processing input loads only on a taken pixel and then holds, so the
    // external chain answer still belongs to the staged word during a stall
    always @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            PROC_IN_O <= `CTPG_PIX_RST;
        else if (take)
            PROC_IN_O <= pat_on ? gen_pix : SENSOR_ANALOG_I;
    end

    // Stage slot: the chain answers one cycle after the load, so every word
    // waits here a cycle; costs latency but keeps every data output registered
    always @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            stage_valid_reg <= `CTPG_FLAG_CLR;
            stage_byp_reg <= `CTPG_FLAG_CLR;
        end
        else if (take)
        begin
            stage_valid_reg <= `CTPG_FLAG_SET;
            stage_byp_reg <= bypass;
        end
        else if (push)
            stage_valid_reg <= `CTPG_FLAG_CLR;
    end

    // Output select: bypass words keep the raw generator value held in the
    // processing input, all others take the chain's answer for that same word
    always @*
    begin
        if (stage_byp_reg)
            out_pix = PROC_IN_O;
        else
            out_pix = DIGITAL_PROC_I;
    end

    // Two-entry buffer behind the stage; a receiver stall back-pressures the source
    // Ready stays high while the staged word can move on in the same cycle
    assign take = SENSOR_VALID_I && SENSOR_READY_O;
    assign push = stage_valid_reg && (cnt_reg != `CTPG_BUF_FULL);
    assign pop = PIX_VALID_O && PIX_READY_I;
    assign SENSOR_READY_O = !stage_valid_reg || push;
    assign PIX_VALID_O = (cnt_reg != `CTPG_BUF_EMPTY);
    assign PIX_DATA_O = buf0_reg;

    // Buffer storage; the head word stays put while the receiver stalls
    always @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            cnt_reg <= `CTPG_BUF_EMPTY;
            buf0_reg <= `CTPG_PIX_RST;
            buf1_reg <= `CTPG_PIX_RST;
        end
        else
        begin
            case ({push, pop})
                2'b10:
                begin
                    if (cnt_reg == `CTPG_BUF_EMPTY)
                        buf0_reg <= out_pix;
                    else
                        buf1_reg <= out_pix;
                    cnt_reg <= cnt_reg + `CTPG_BUF_ONE;
                end
                2'b01:
                begin
                    buf0_reg <= buf1_reg;
                    cnt_reg <= cnt_reg - `CTPG_BUF_ONE;
                end
                2'b11:
                begin
                    if (cnt_reg == `CTPG_BUF_ONE)
                        buf0_reg <= out_pix;
                    else
                    begin
                        buf0_reg <= buf1_reg;
                        buf1_reg <= out_pix;
                    end
                end
                default:
                    cnt_reg <= cnt_reg;
            endcase
        end
    end
endmodule

//--- ctpg_lut_model.sv
`timescale 1ns/1ps
module ctpg_lut_model(
    input wire [11:0] in_i,
    output wire [11:0] out_o
);
    // Inverting table, so any missed bypass shows
    assign out_o = ~in_i;
endmodule

//--- ctpg_chk.sv
`timescale 1ns/1ps
module ctpg_chk #(parameter PIX_W = 12)(
    input wire CLK_SYS_I,
    input wire RST_N_I,
    input wire [2:0] PATTERN_CHOICE_I,
    input wire FRAME_START_I,
    input wire SENSOR_VALID_I,
    input wire SENSOR_READY_O,
    input wire USE_ANALOG_O,
    input wire USE_DIGITAL_O,
    input wire PIX_VALID_O,
    input wire [PIX_W-1:0] PIX_DATA_O,
    input wire PIX_READY_I
);
    wire fs = FRAME_START_I;
    wire [2:0] ch = PATTERN_CHOICE_I;
    wire ua = USE_ANALOG_O;
    wire ud = USE_DIGITAL_O;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // Stall must not lose or alter the head word
    hold_a: assert property (PIX_VALID_O && !PIX_READY_I |=> PIX_VALID_O && $stable(PIX_DATA_O))
        else $error("word lost");
    push_a: assert property (SENSOR_VALID_I && SENSOR_READY_O |-> ##2 PIX_VALID_O)
        else $error("no word");
    room_a: assert property (!PIX_VALID_O |-> SENSOR_READY_O) else $error("no room");
    // Path flags settle within two cycles of the pulse
    bypass_a: assert property (fs && ch inside {3'h1, 3'h2, 3'h3} |-> ##[1:2] !ua && !ud)
        else $error("no bypass");
    feat_a: assert property (fs && ch inside {3'h4, 3'h5} |-> ##[1:2] !ua && ud)
        else $error("no chain");
    off_a: assert property (fs && ch == 3'h0 |-> ##[1:2] ua && ud) else $error("off");
    color_a: assert property (fs && ch == 3'h6 |-> ##[1:2] !ud) else $error("color");
    analog_a: assert property (!ud |-> !ua) else $error("analog");
    cover property (fs && ch == 3'h5);
    cover property (PIX_VALID_O && !SENSOR_READY_O);
    cover property (PIX_VALID_O && PIX_READY_I);
endmodule
bind ctpg_top ctpg_chk #(.PIX_W(PIX_W)) chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
    .PATTERN_CHOICE_I(PATTERN_CHOICE_I), .FRAME_START_I(FRAME_START_I),
    .SENSOR_VALID_I(SENSOR_VALID_I), .SENSOR_READY_O(SENSOR_READY_O),
    .USE_ANALOG_O(USE_ANALOG_O), .USE_DIGITAL_O(USE_DIGITAL_O), .PIX_VALID_O(PIX_VALID_O),
    .PIX_DATA_O(PIX_DATA_O), .PIX_READY_I(PIX_READY_I));

//--- camera_test_pattern_generator_test.sv
`timescale 1ns/1ps
module camera_test_pattern_generator_test;
    reg clk = 1'h0, rst_n = 1'h0, fs = 1'h0, sv = 1'h0, pr = 1'h0;
    reg [2:0] sel = 3'h0;
    reg [11:0] col = 12'h000, row = 12'h000, cnt = 12'h000;
    wire srdy, pv, ua, ud;
    wire [11:0] pin, dp, pd;
    integer miscompares = 0, check_count = 0, cyc = 0;
    ctpg_top dut(.CLK_SYS_I(clk), .RST_N_I(rst_n), .PATTERN_CHOICE_I(sel), .FRAME_START_I(fs),
        .COL_I(col), .ROW_I(row), .SENSOR_VALID_I(sv), .SENSOR_RAW_I(12'h000),
        .SENSOR_ANALOG_I(12'h5a3), .DIGITAL_PROC_I(dp), .SENSOR_READY_O(srdy), .PROC_IN_O(pin),
        .USE_ANALOG_O(ua), .USE_DIGITAL_O(ud), .PIX_VALID_O(pv), .PIX_DATA_O(pd), .PIX_READY_I(pr));
    ctpg_lut_model lut(.in_i(pin), .out_o(dp));
    initial forever #20 clk = ~clk;
    // Hang guard, far above the run length
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 2000)
        begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    task final_report;
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cmp(input [11:0] g, input [11:0] e);
        check_count = check_count + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    // Pulse selects the pattern and bumps our frame count
    task frame(input [2:0] s);
        @(negedge clk) sel = s;
        fs = 1'h1;
        cnt = cnt + 12'h001;
        @(negedge clk) fs = 1'h0;
    endtask
    task push(input [11:0] c, input [11:0] r);
        @(negedge clk) col = c;
        row = r;
        sv = 1'h1;
        @(negedge clk) sv = 1'h0;
    endtask
    task pop(input [11:0] e);
        @(negedge clk) cmp(pv, 12'h001);
        cmp(pd, e);
        pr = 1'h1;
        @(negedge clk) pr = 1'h0;
    endtask
    task t_move;
        frame(3'h2);
        push(12'h005, 12'h007);
        pop((12'h00c + cnt) & 12'h0ff);
        frame(3'h2);
        push(12'h004, 12'h007);
        pop((12'h00b + cnt) & 12'h0ff);
        frame(3'h3);
        push(12'hfff, 12'h001);
        pop(cnt);
    endtask
    task t_first;
        frame(3'h1);
        push(12'h0ff, 12'h0f3);
        pop(12'h0f2);
        cmp(ua, 12'h000);
    endtask
    task t_feat;
        frame(3'h4);
        push(12'h003, 12'h003);
        pop(~((12'h006 + cnt) & 12'h0ff));
        frame(3'h5);
        push(12'h800, 12'h7ff);
        pop(~(12'hfff + cnt));
    endtask
    task t_off;
        frame(3'h0);
        push(12'h001, 12'h001);
        pop(~12'h5a3);
    endtask
    // Three words fill stage and buffer; the fourth is refused
    task t_stall;
        frame(3'h1);
        push(12'h001, 12'h001);
        push(12'h002, 12'h002);
        push(12'h003, 12'h003);
        cmp(srdy, 12'h000);
        pop(12'h002);
        pop(12'h004);
        pop(12'h006);
        frame(3'h6);
        @(negedge clk) cmp(ud, 12'h000);
        push(12'h002, 12'h003);
        pop((12'h005 + cnt) & 12'h0ff);
        frame(3'h7);
        @(negedge clk) cmp(ua, 12'h001);
    endtask
    initial
    begin
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        cmp(ud, 12'h001);
        t_move;
        t_first;
        t_feat;
        t_off;
        t_stall;
        final_report;
    end
endmodule
